/* src/core_addr_pkg.sv */
package core_addr_pkg;
	// Program side
	localparam int PC_W = 14;
	localparam int PAGE_SEL_W = 3;
	localparam int IN_PAGE_W = 11;
	localparam int STACK_DEPTH = 16;
	localparam int TAB_W = 16;
	localparam int ROM_DATA_W = 16;
	// Data memory side
	localparam int RAM_ADDR_W = 11;
	localparam int RAM_WORDS = 2048;
	localparam int NIB_W = 4;
	localparam int DIRECT_OFF_W = 7;
	localparam int PAGE_OFF_W = 4;
	// Reset values
	localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
	localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
	localparam logic [TAB_W-1:0] TAB_RESET = 16'h0000;
	// Wishbone byte offsets
	localparam logic [7:0] OFF_PROG_PAGE = 8'h00;
	localparam logic [7:0] OFF_IND_PAGE = 8'h04;
	localparam logic [7:0] OFF_WR_PAGE = 8'h08;
	localparam logic [7:0] OFF_DATA_BANK = 8'h0C;
	localparam logic [7:0] OFF_CORE_STAT = 8'h10;
	localparam logic [7:0] OFF_PC = 8'h14;
	localparam logic [7:0] OFF_TAB_PTR = 8'h18;
	// Status word field positions
	localparam int STAT_CARRY_BIT = 4;
	localparam int STAT_ZERO_BIT = 5;
	localparam int STAT_BUSY_BIT = 6;
	// Sequencer register selects
	localparam logic [1:0] SEL_PROG_PAGE = 2'h0;
	localparam logic [1:0] SEL_IND_PAGE = 2'h1;
	localparam logic [1:0] SEL_WR_PAGE = 2'h2;
	localparam logic [1:0] SEL_DATA_BANK = 2'h3;

	typedef enum logic [1:0] {
		RAM_DIRECT = 2'h0,
		RAM_INDIRECT = 2'h1,
		RAM_WORKING = 2'h2
	} ram_mode_type;

	typedef enum logic [1:0] {
		TBL_IDLE = 2'h0,
		TBL_FETCH = 2'h1,
		TBL_WRITE = 2'h3
	} tbl_state_type;

	function automatic logic [PC_W-1:0] irq_vector(input logic [2:0] idx);
		case (idx)
			3'h0: irq_vector = 14'h0004;
			3'h1: irq_vector = 14'h0008;
			3'h2: irq_vector = 14'h000C;
			3'h3: irq_vector = 14'h0014;
			3'h4: irq_vector = 14'h0020;
			default: irq_vector = PC_RESET;
		endcase
	endfunction
endpackage

/* src/stack_if.sv */
`timescale 1ns/10ps
interface stack_if #(parameter int W = 14);
	logic push;
	logic pop;
	logic [W-1:0] push_data;
	logic [W-1:0] top_data;
	modport owner(output push, output pop, output push_data, input top_data);
	modport store(input push, input pop, input push_data, output top_data);
endinterface

/* src/return_stack.sv */
`timescale 1ns/10ps
module return_stack
	import core_addr_pkg::*;
#(
	parameter int W = PC_W,
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic core_clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	stack_if.store st // Push and pop port
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] ptr_ff;
	logic [PW-1:0] top_idx;

	assign top_idx = ptr_ff - 1'b1;
	assign st.top_data = mem[top_idx];

	// Circular pointer: an extra push lands on the oldest entry
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ptr_ff <= '0;
		end else if (st.push) begin
			ptr_ff <= ptr_ff + 1'b1;
		end else if (st.pop) begin
			ptr_ff <= top_idx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (st.push) begin
			mem[ptr_ff] <= st.push_data;
		end
	end
endmodule

/* src/core_stack_and_memory_banking.sv */
`timescale 1ns/10ps
// Function
// - Sixteen-entry return stack pushes program counter on every interrupt, else program counter plus one on a call without a return.
// - Return instruction pops the top stack entry into the program counter.
// - Pushing past sixteen levels overwrites the oldest entry; depth stays sixteen.
// - Program memory is 16384 words of 16 bits in eight 2048-word pages.
// - Write-only page register bits 2:0 pick jump and call page; bit 3 reserved.
// - Program memory reads as 65536 nibbles addressed by the table pointer.
// - Table read fetches the pointed nibble and writes it into selected RAM.
// - Data RAM is 2048 nibbles in sixteen banks; direct and indirect accesses use selected bank.
// - Data bank value n selects RAM n*0x80 through n*0x80+0x7F.
// - Indirect page bits 2:0 select sixteen-nibble page inside the bank; bit 3 reserved.
// - Banks 0 and 1 form sixteen working-register pages chosen by page value.
// - Only the selected working page acts as registers; rest is ordinary memory.
// - Immediate-operand instructions accept working registers but never ordinary data memory.
// - Four-bit accumulator takes ALU results and moves data between memory and registers.
// - Logic, branch, shift, add and subtract update carry and zero; carry movable to RAM.
// - Program counter is fourteen bits wide covering all program words.
// - Reset loads address 0000H; accepted interrupt loads its fixed vector directly.
module core_stack_and_memory_banking
	import core_addr_pkg::*;
#(
	parameter int RAM_DEPTH = RAM_WORDS
) (
	input wire logic core_clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	// Wishbone slave
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	// Program flow from the sequencer
	input wire logic step, // Advance program counter by one
	input wire logic call_take, // Subroutine call
	input wire logic jump_take, // Paged jump
	input wire logic branch_take, // In-page branch or skip
	input wire logic ret_take, // Return instruction
	input wire logic irq_take, // Interrupt accepted
	input wire logic [2:0] irq_index, // Interrupt source number
	input wire logic [IN_PAGE_W-1:0] target, // In-page destination
	output logic [PC_W-1:0] program_counter, // Current program counter
	// Program memory port
	output logic [PC_W-1:0] rom_addr, // Word address
	input wire logic [ROM_DATA_W-1:0] rom_rdata, // Word read, one cycle after address
	// Register writes from instructions
	input wire logic seqreg_we, // Select register write
	input wire logic [1:0] seqreg_sel, // Which select register
	input wire logic [NIB_W-1:0] seqreg_wdata, // Value
	input wire logic tab_we, // Table pointer nibble write
	input wire logic [1:0] tab_nibble, // Nibble number, 0 lowest
	input wire logic [NIB_W-1:0] tab_wdata, // Nibble value
	input wire logic table_read, // Table read instruction
	output logic table_busy, // Table read in progress
	// Data memory access
	input wire logic ram_en, // Data access this cycle
	input wire logic ram_we, // Write access
	input wire logic [1:0] ram_mode, // Direct, indirect or working
	input wire logic [DIRECT_OFF_W-1:0] ram_offset, // Offset in bank or page
	input wire logic imm_op, // Instruction carries immediate operand
	input wire logic [NIB_W-1:0] ram_wdata, // Write nibble
	input wire logic ram_wr_carry, // Write carry flag instead of data
	output logic [NIB_W-1:0] ram_rdata, // Read nibble
	output logic op_refused, // Immediate with ordinary memory, one-cycle pulse
	// Accumulator and flags
	input wire logic acc_we, // Load accumulator
	input wire logic acc_from_ram, // Source is data memory read
	input wire logic [NIB_W-1:0] alu_result, // ALU result
	input wire logic flag_we, // Update flags
	input wire logic alu_carry, // New carry
	input wire logic alu_zero, // New zero
	output logic [NIB_W-1:0] accumulator, // Accumulator
	output logic carry_flag, // Carry
	output logic zero_flag // Zero
);
	logic [NIB_W-1:0] mem [0:RAM_DEPTH-1];
	logic [PC_W-1:0] pc_ff;
	logic [PC_W-1:0] nxt_pc;
	logic [PC_W-1:0] rom_addr_ff;
	logic [PAGE_SEL_W-1:0] prog_page_ff;
	logic [PAGE_SEL_W-1:0] ind_page_ff;
	logic [NIB_W-1:0] wr_page_ff;
	logic [NIB_W-1:0] data_bank_ff;
	logic [TAB_W-1:0] tab_ptr_ff;
	logic [NIB_W-1:0] acc_ff;
	logic carry_ff;
	logic zero_ff;
	logic [NIB_W-1:0] ram_rdata_ff;
	logic refused_ff;
	tbl_state_type tbl_state_ff;
	tbl_state_type nxt_tbl_state;
	logic [RAM_ADDR_W-1:0] tbl_dest_ff;
	logic [RAM_ADDR_W-1:0] acc_addr;
	logic access_ok;
	logic [NIB_W-1:0] tbl_nibble;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic bus_req;
	logic bus_wr;
	logic [31:0] bus_word;
	stack_if #(.W(PC_W)) stk();

	// Address of a data access in each mode
	function automatic logic [RAM_ADDR_W-1:0] ram_address(
		input logic [1:0] mode,
		input logic [DIRECT_OFF_W-1:0] off,
		input logic [NIB_W-1:0] bank,
		input logic [PAGE_SEL_W-1:0] page,
		input logic [NIB_W-1:0] working_reg_page_select
	);
		case (mode)
			RAM_DIRECT: ram_address = {bank, off};
			RAM_INDIRECT: ram_address = {bank, page, off[PAGE_OFF_W-1:0]};
			RAM_WORKING: ram_address = {3'h0, working_reg_page_select, off[PAGE_OFF_W-1:0]};
			default: ram_address = {bank, off};
		endcase
	endfunction

	// Pick a nibble out of a program word
	function automatic logic [NIB_W-1:0] word_nibble(
		input logic [ROM_DATA_W-1:0] word,
		input logic [1:0] idx
	);
		case (idx)
			2'h0: word_nibble = word[3:0];
			2'h1: word_nibble = word[7:4];
			2'h2: word_nibble = word[11:8];
			2'h3: word_nibble = word[15:12];
			default: word_nibble = word[3:0];
		endcase
	endfunction

	return_stack #(.W(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
		.core_clk(core_clk),
		.reset(reset),
		.st(stk.store)
	);

	// Program counter: interrupt, return, call, jump, branch, step
	always_comb begin
		nxt_pc = pc_ff;
		if (irq_take) begin
			nxt_pc = irq_vector(irq_index);
		end else if (ret_take) begin
			nxt_pc = stk.top_data;
		end else if (call_take || jump_take) begin
			nxt_pc = {prog_page_ff, target};
		end else if (branch_take) begin
			nxt_pc = {pc_ff[PC_W-1:IN_PAGE_W], target};
		end else if (step) begin
			nxt_pc = pc_ff + 1'b1;
		end
	end

	assign stk.push = irq_take || (call_take && !ret_take);
	assign stk.pop = ret_take && !irq_take;
	assign stk.push_data = irq_take ? pc_ff : PC_W'(pc_ff + 1'b1);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pc_ff <= PC_RESET;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	// Bus handshake: one-cycle ack after the strobe
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_wr = bus_req && wb_we_i;
	assign bus_word = wb_dat_i;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req;
		end
	end

	// Select registers: instruction write wins over a bus write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prog_page_ff <= '0;
		end else if (seqreg_we && seqreg_sel == SEL_PROG_PAGE) begin
			prog_page_ff <= seqreg_wdata[PAGE_SEL_W-1:0];
		end else if (bus_wr && wb_sel_i[0] && wb_adr_i == OFF_PROG_PAGE) begin
			prog_page_ff <= bus_word[PAGE_SEL_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ind_page_ff <= '0;
		end else if (seqreg_we && seqreg_sel == SEL_IND_PAGE) begin
			ind_page_ff <= seqreg_wdata[PAGE_SEL_W-1:0];
		end else if (bus_wr && wb_sel_i[0] && wb_adr_i == OFF_IND_PAGE) begin
			ind_page_ff <= bus_word[PAGE_SEL_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_page_ff <= NIB_RESET;
		end else if (seqreg_we && seqreg_sel == SEL_WR_PAGE) begin
			wr_page_ff <= seqreg_wdata;
		end else if (bus_wr && wb_sel_i[0] && wb_adr_i == OFF_WR_PAGE) begin
			wr_page_ff <= bus_word[NIB_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			data_bank_ff <= NIB_RESET;
		end else if (seqreg_we && seqreg_sel == SEL_DATA_BANK) begin
			data_bank_ff <= seqreg_wdata;
		end else if (bus_wr && wb_sel_i[0] && wb_adr_i == OFF_DATA_BANK) begin
			data_bank_ff <= bus_word[NIB_W-1:0];
		end
	end

	// Table pointer, nibble-wise from instructions, byte-wise from the bus
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tab_ptr_ff <= TAB_RESET;
		end else if (tab_we) begin
			tab_ptr_ff[tab_nibble*NIB_W +: NIB_W] <= tab_wdata;
		end else if (bus_wr && wb_adr_i == OFF_TAB_PTR) begin
			if (wb_sel_i[0]) begin
				tab_ptr_ff[7:0] <= bus_word[7:0];
			end
			if (wb_sel_i[1]) begin
				tab_ptr_ff[15:8] <= bus_word[15:8];
			end
		end
	end

	// Table read sequence: present word, wait for ROM, store nibble
	always_comb begin
		nxt_tbl_state = tbl_state_ff;
		case (tbl_state_ff)
			TBL_IDLE: begin
				if (table_read) begin
					nxt_tbl_state = TBL_FETCH;
				end
			end
			TBL_FETCH: nxt_tbl_state = TBL_WRITE;
			TBL_WRITE: nxt_tbl_state = TBL_IDLE;
			default: nxt_tbl_state = TBL_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tbl_state_ff <= TBL_IDLE;
		end else begin
			tbl_state_ff <= nxt_tbl_state;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tbl_dest_ff <= '0;
		end else if (tbl_state_ff == TBL_IDLE && table_read) begin
			tbl_dest_ff <= ram_address(ram_mode, ram_offset, data_bank_ff, ind_page_ff, wr_page_ff);
		end
	end

	// Word address is pointer bits 15:2, nibble is bits 1:0
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rom_addr_ff <= PC_RESET;
		end else if (tbl_state_ff == TBL_IDLE && table_read) begin
			rom_addr_ff <= tab_ptr_ff[TAB_W-1:2];
		end else if (tbl_state_ff == TBL_IDLE || tbl_state_ff == TBL_WRITE) begin
			rom_addr_ff <= nxt_pc;
		end
	end

	assign tbl_nibble = word_nibble(rom_rdata, tab_ptr_ff[1:0]);

	// Data memory access
	assign acc_addr = ram_address(ram_mode, ram_offset, data_bank_ff, ind_page_ff, wr_page_ff);
	assign access_ok = !(imm_op && ram_mode != RAM_WORKING);

	always_ff @(posedge core_clk) begin
		if (tbl_state_ff == TBL_WRITE) begin
			mem[tbl_dest_ff] <= tbl_nibble;
		end else if (ram_en && ram_we && access_ok) begin
			mem[acc_addr] <= ram_wr_carry ? {3'h0, carry_ff} : ram_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ram_rdata_ff <= NIB_RESET;
		end else if (ram_en && !ram_we && access_ok) begin
			ram_rdata_ff <= mem[acc_addr];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			refused_ff <= 1'b0;
		end else begin
			refused_ff <= ram_en && !access_ok;
		end
	end

	// Accumulator and flags
	always_ff @(posedge core_clk) begin
		if (reset) begin
			acc_ff <= NIB_RESET;
		end else if (acc_we) begin
			acc_ff <= acc_from_ram ? ram_rdata_ff : alu_result;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			carry_ff <= 1'b0;
			zero_ff <= 1'b0;
		end else if (flag_we) begin
			carry_ff <= alu_carry;
			zero_ff <= alu_zero;
		end
	end

	// Bus read data; program page reads zero, unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_ff <= 32'h00000000;
		end else if (bus_req) begin
			case (wb_adr_i)
				OFF_IND_PAGE: rdata_ff <= {29'h0, ind_page_ff};
				OFF_WR_PAGE: rdata_ff <= {28'h0, wr_page_ff};
				OFF_DATA_BANK: rdata_ff <= {28'h0, data_bank_ff};
				OFF_CORE_STAT: rdata_ff <= {25'h0, table_busy, zero_ff, carry_ff, acc_ff};
				OFF_PC: rdata_ff <= {18'h0, pc_ff};
				OFF_TAB_PTR: rdata_ff <= {16'h0, tab_ptr_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign program_counter = pc_ff;
	assign rom_addr = rom_addr_ff;
	assign table_busy = tbl_state_ff != TBL_IDLE;
	assign ram_rdata = ram_rdata_ff;
	assign op_refused = refused_ff;
	assign accumulator = acc_ff;
	assign carry_flag = carry_ff;
	assign zero_flag = zero_ff;
endmodule

/* sim/rom_model.sv */
`timescale 1ns/10ps
module rom_model
	import core_addr_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic [PC_W-1:0] rom_addr, // Word address
	output logic [ROM_DATA_W-1:0] rom_rdata // Word, one cycle later
);
	// Content derived from address so every word differs
	always_ff @(posedge core_clk) begin
		rom_rdata <= {2'h0, rom_addr} ^ 16'h5A3C;
	end
endmodule

/* sim/core_props_properties.sv */
`timescale 1ns/10ps
module core_props
	import core_addr_pkg::*;
#(
	parameter int RAM_DEPTH = RAM_WORDS
) (
	input wire logic core_clk, // Clock
	input wire logic reset, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_ack_o, // Ack
	input wire logic step, // Step
	input wire logic call_take, // Call
	input wire logic jump_take, // Jump
	input wire logic branch_take, // Branch
	input wire logic ret_take, // Return
	input wire logic irq_take, // Interrupt
	input wire logic [2:0] irq_index, // Source
	input wire logic [IN_PAGE_W-1:0] target, // Target
	input wire logic [PC_W-1:0] program_counter, // PC
	input wire logic [PC_W-1:0] rom_addr, // ROM address
	input wire logic table_read, // Table read
	input wire logic table_busy, // Busy
	input wire logic ram_en, // RAM access
	input wire logic imm_op, // Immediate
	input wire logic [1:0] ram_mode, // Mode
	input wire logic op_refused, // Refused
	input wire logic flag_we, // Flag load
	input wire logic alu_carry, // New carry
	input wire logic alu_zero, // New zero
	input wire logic carry_flag, // Carry
	input wire logic zero_flag // Zero
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");
	AST_RESET_PC: assert property ($fell(reset) |-> program_counter == 14'h0000 && rom_addr == 14'h0000)
		else $error("pc not zero after reset");
	AST_IRQ_VEC: assert property (irq_take && irq_index == 3'h4 |=> program_counter == 14'h0020)
		else $error("wrong interrupt vector");
	AST_STEP: assert property (step && !(irq_take || ret_take || call_take || jump_take || branch_take)
		|=> program_counter == $past(program_counter) + 14'h1)
		else $error("pc did not advance by one");
	AST_BRANCH: assert property (branch_take && !(irq_take || ret_take || call_take || jump_take) |=>
		program_counter[10:0] == $past(target) && program_counter[13:11] == $past(program_counter[13:11]))
		else $error("branch left its page");
	AST_CALL_RET: assert property (call_take && !irq_take && !ret_take ##1 ret_take && !irq_take
		|=> program_counter == $past(program_counter, 2) + 14'h1)
		else $error("return did not restore caller");
	AST_TBL_BUSY: assert property (table_read && !table_busy |=> table_busy [*2] ##1 !table_busy)
		else $error("table read length wrong");
	AST_ROM_PC: assert property (!table_busy |-> rom_addr == program_counter)
		else $error("rom address differs from pc");
	AST_REFUSE: assert property (ram_en && imm_op |=> op_refused == ($past(ram_mode) != 2'h2))
		else $error("immediate refusal wrong");
	AST_FLAGS: assert property (flag_we |=> carry_flag == $past(alu_carry) && zero_flag == $past(alu_zero))
		else $error("flags not loaded");
endmodule
bind core_stack_and_memory_banking core_props #(.RAM_DEPTH(RAM_DEPTH)) i_props (.*);

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top
	import core_addr_pkg::*;
;
	localparam logic [15:0] TV = 16'h1236;
	logic core_clk = 1'h0;
	logic reset = 1'h1;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [5:0] cmd = 6'h00;
	logic step, call_take, jump_take, branch_take, ret_take, irq_take;
	logic [2:0] irq_index = 3'h0;
	logic [10:0] target = 11'h000;
	logic [13:0] program_counter, rom_addr, cur;
	logic [13:0] pushed [0:16];
	logic [13:0] vec [0:5] = '{14'h0004, 14'h0008, 14'h000C, 14'h0014, 14'h0020, 14'h0000};
	logic [15:0] rom_rdata;
	logic seqreg_we = 1'h0, tab_we = 1'h0, table_read = 1'h0, table_busy;
	logic [1:0] seqreg_sel = 2'h0, tab_nibble = 2'h0, ram_mode = 2'h0;
	logic [3:0] seqreg_wdata = 4'h0, tab_wdata = 4'h0, ram_wdata = 4'h0, alu_result = 4'h0, ram_rdata, accumulator;
	logic ram_en = 1'h0, ram_we = 1'h0, imm_op = 1'h0, ram_wr_carry = 1'h0, op_refused;
	logic [6:0] ram_offset = 7'h00;
	logic acc_we = 1'h0, acc_from_ram = 1'h0, flag_we = 1'h0, alu_carry = 1'h0, alu_zero = 1'h0, carry_flag, zero_flag;
	int num_errors = 0, comparisons = 0;
	assign {irq_take, ret_take, call_take, jump_take, branch_take, step} = cmd;
	always #12.5 core_clk = ~core_clk;
	core_stack_and_memory_banking i_dut (.*);
	rom_model i_rom (.core_clk(core_clk), .rom_addr(rom_addr), .rom_rdata(rom_rdata));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic fl(input logic [5:0] c, input logic [10:0] t);
		@(posedge core_clk);
		cmd <= c;
		target <= t;
		@(posedge core_clk);
		cmd <= 6'h00;
		#1;
	endtask
	task automatic sr(input logic [1:0] s, input logic [3:0] v);
		@(posedge core_clk);
		seqreg_we <= 1'h1;
		seqreg_sel <= s;
		seqreg_wdata <= v;
		@(posedge core_clk);
		seqreg_we <= 1'h0;
	endtask
	task automatic ram(input logic w, input logic [1:0] m, input logic [6:0] o, input logic [3:0] d, input logic im,
		input logic c);
		@(posedge core_clk);
		ram_en <= 1'h1;
		ram_we <= w;
		ram_mode <= m;
		ram_offset <= o;
		ram_wdata <= d;
		imm_op <= im;
		ram_wr_carry <= c;
		@(posedge core_clk);
		ram_en <= 1'h0;
		imm_op <= 1'h0;
		#1;
	endtask
	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'h0;
		for (int i = 0; i < 7; i++) begin
			wb(1'h0, 8'(i * 4), 32'h0);
			chk("reset value", 32'h0, q);
		end
		wb(1'h1, OFF_IND_PAGE, 32'hF);
		wb(1'h0, OFF_IND_PAGE, 32'h0);
		chk("indirect page", 32'h7, q);
		wb(1'h1, OFF_WR_PAGE, 32'hF);
		wb(1'h0, OFF_WR_PAGE, 32'h0);
		chk("working page", 32'hF, q);
		wb(1'h1, OFF_PROG_PAGE, 32'h5);
		wb(1'h0, OFF_PROG_PAGE, 32'h0);
		chk("program page read", 32'h0, q);
		wb(1'h0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, q);
		fl(6'h04, 11'h123);
		cur = 14'h2923;
		chk("jump pc", cur, program_counter);
		@(posedge core_clk);
		cmd <= 6'h08;
		target <= 11'h200;
		@(posedge core_clk);
		cmd <= 6'h10;
		@(posedge core_clk);
		cmd <= 6'h00;
		#1;
		cur = cur + 14'h1;
		chk("call return pc", cur, program_counter);
		for (int i = 0; i < 17; i++) begin
			pushed[i] = cur + 14'h1;
			cur = {3'h5, i[6:0], 4'h0};
			fl(6'h08, cur[10:0]);
			chk("call pc", cur, program_counter);
		end
		for (int i = 16; i > 0; i--) begin
			fl(6'h10, 11'h000);
			chk("pop pc", pushed[i], program_counter);
		end
		cur = pushed[1];
		for (int i = 0; i < 6; i++) begin
			irq_index <= i[2:0];
			fl(6'h20, 11'h000);
			chk("vector", vec[i], program_counter);
			fl(6'h10, 11'h000);
			chk("interrupt return", cur, program_counter);
		end
		wb(1'h1, OFF_PROG_PAGE, 32'h2);
		fl(6'h02, 11'h7FF);
		cur = {cur[13:11], 11'h7FF};
		chk("branch pc", cur, program_counter);
		fl(6'h01, 11'h000);
		chk("step pc", cur + 14'h1, program_counter);
		sr(2'h2, 4'hF);
		ram(1'h1, 2'h2, 7'h03, 4'hA, 1'h0, 1'h0);
		sr(2'h3, 4'h1);
		ram(1'h0, 2'h0, 7'h73, 4'h0, 1'h0, 1'h0);
		chk("direct view", 32'hA, ram_rdata);
		sr(2'h1, 4'h7);
		ram(1'h0, 2'h1, 7'h03, 4'h0, 1'h0, 1'h0);
		chk("indirect view", 32'hA, ram_rdata);
		ram(1'h1, 2'h0, 7'h10, 4'h6, 1'h0, 1'h0);
		sr(2'h2, 4'h9);
		ram(1'h0, 2'h2, 7'h00, 4'h0, 1'h0, 1'h0);
		chk("working view", 32'h6, ram_rdata);
		ram(1'h0, 2'h0, 7'h00, 4'h0, 1'h1, 1'h0);
		chk("refused", 32'h1, op_refused);
		ram(1'h0, 2'h2, 7'h00, 4'h0, 1'h1, 1'h0);
		chk("accepted", 32'h0, op_refused);
		@(posedge core_clk);
		acc_we <= 1'h1;
		alu_result <= 4'h9;
		flag_we <= 1'h1;
		alu_carry <= 1'h1;
		alu_zero <= 1'h1;
		@(posedge core_clk);
		acc_we <= 1'h0;
		flag_we <= 1'h0;
		#1;
		chk("accumulator out", 32'h9, accumulator);
		chk("flags out", 32'h3, {zero_flag, carry_flag});
		wb(1'h0, OFF_CORE_STAT, 32'h0);
		chk("status", 32'h39, q);
		ram(1'h1, 2'h2, 7'h04, 4'h0, 1'h0, 1'h1);
		ram(1'h0, 2'h2, 7'h04, 4'h0, 1'h0, 1'h0);
		chk("carry store", 32'h1, ram_rdata);
		ram(1'h0, 2'h2, 7'h00, 4'h0, 1'h0, 1'h0);
		@(posedge core_clk);
		acc_we <= 1'h1;
		acc_from_ram <= 1'h1;
		@(posedge core_clk);
		acc_we <= 1'h0;
		acc_from_ram <= 1'h0;
		wb(1'h0, OFF_CORE_STAT, 32'h0);
		chk("accumulator", 32'h36, q);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			tab_we <= 1'h1;
			tab_nibble <= i[1:0];
			tab_wdata <= TV[i * 4 +: 4];
		end
		@(posedge core_clk);
		tab_we <= 1'h0;
		wb(1'h0, OFF_TAB_PTR, 32'h0);
		chk("table pointer", 32'(TV), q);
		sr(2'h3, 4'h3);
		@(posedge core_clk);
		table_read <= 1'h1;
		ram_mode <= 2'h0;
		ram_offset <= 7'h05;
		@(posedge core_clk);
		table_read <= 1'h0;
		#1;
		chk("busy", 32'h1, table_busy);
		chk("table rom address", 32'(TV[15:2]), rom_addr);
		repeat (3) @(posedge core_clk);
		ram(1'h0, 2'h0, 7'h05, 4'h0, 1'h0, 1'h0);
		chk("table data", (({2'h0, TV[15:2]} ^ 16'h5A3C) >> (TV[1:0] * 4)) & 16'hF, ram_rdata);
		final_report;
	end
	initial begin
		repeat (4000) @(posedge core_clk);
		num_errors++;
		final_report;
	end
endmodule
